// ===== rtl/audio_clock_pkg.sv
`default_nettype none

package audio_clock_pkg;

    // register offsets of the byte register port
    localparam logic [7:0] CPF_LOW_ADDR = 8'h30;
    localparam logic [7:0] CPF_MID_ADDR = 8'h31;
    localparam logic [7:0] CPF_HIGH_ADDR = 8'h32;
    localparam logic [7:0] INC_LOW_ADDR = 8'h34;
    localparam logic [7:0] INC_MID_ADDR = 8'h35;
    localparam logic [7:0] INC_HIGH_ADDR = 8'h36;
    localparam logic [7:0] SERIAL_DIV_ADDR = 8'h38;
    localparam logic [7:0] CHANNEL_DIV_ADDR = 8'h39;
    localparam logic [7:0] CONTROL_ADDR = 8'h3A;
    localparam logic [7:0] STATUS_ADDR = 8'h3B;

    // field widths
    localparam int CPF_W = 18;
    localparam int INC_W = 22;
    localparam int ACC_W = 23;
    localparam int DIV_W = 6;
    localparam int TRIM_W = 12;

    // control byte bit positions
    localparam int CTRL_SERIAL_PH_BIT = 0;
    localparam int CTRL_CHANNEL_PH_BIT = 1;
    localparam int CTRL_VREF_SEL_BIT = 2;
    localparam int CTRL_LOOP_OPEN_BIT = 3;
    localparam int CTRL_W = 4;

    // status byte bit positions
    localparam int STAT_XTAL_SEL_BIT = 0;
    localparam int STAT_MATCH_BIT = 1;

    // values after reset
    localparam logic [CPF_W-1:0] CPF_RESET = '0;
    localparam logic [INC_W-1:0] INC_RESET = '0;
    localparam logic [DIV_W-1:0] SERIAL_DIV_RESET = '0;
    localparam logic [DIV_W-1:0] CHANNEL_DIV_RESET = '0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = '0;
    localparam logic [TRIM_W-1:0] TRIM_RESET = '0;

    // pin synchroniser lanes
    localparam int PIN_VREF = 0;
    localparam int PIN_MCLK = 1;
    localparam int PIN_STRAP = 2;
    localparam int PIN_N = 3;

endpackage : audio_clock_pkg

`default_nettype wire

// ===== rtl/field_locked_audio_clock_gen.sv
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - master audio clock is locked to video field rate, fixed clock count per field
// - master audio clock is synthesized from the crystal clock shared with pixel clock
// - 18-bit clocks-per-field value spread over three byte registers
// - 22-bit nominal increment, audio over crystal times 2^23, three byte registers
// - serial bit clock is external master clock divided by twice the divider plus two
// - channel clock is serial bit clock divided by twice channel divider
// - two binary divided clocks: serial bit clock and channel select clock
// - loop open bit: 0 keeps field lock closed, 1 runs at nominal increment
// - vertical reference select: 0 internal, 1 external reference pin
// - channel phase: 1 channel follows rising serial edges, 0 serial inverted
// - serial phase: 0 follows falling master input edges, 1 rising edges
// - crystal choice is strapped on channel clock pin during reset
module field_locked_audio_clock_gen
    import audio_clock_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    input wire logic VREF_INT_IN,
    input wire logic VREF_EXT_PIN_IN,
    input wire logic EXT_MASTER_CLK_IN,
    input wire logic CHANNEL_CLK_PIN_IN,
    output logic MASTER_AUDIO_CLK_OUT,
    output logic SERIAL_BIT_CLK_OUT,
    output logic CHANNEL_SELECT_CLK_OUT,
    output logic CHANNEL_SELECT_CLK_OE_N_OUT,
    output logic XTAL_SELECT_OUT
);

    logic [CPF_W-1:0] clocks_per_field_ff;
    logic [INC_W-1:0] nominal_increment_ff;
    logic [DIV_W-1:0] serial_divider_ff;
    logic [DIV_W-1:0] channel_divider_ff;
    logic [CTRL_W-1:0] control_ff;
    logic loop_open_select;
    logic vertical_ref_select;
    logic channel_clock_phase;
    logic serial_clock_phase;

    assign loop_open_select = control_ff[CTRL_LOOP_OPEN_BIT];
    assign vertical_ref_select = control_ff[CTRL_VREF_SEL_BIT];
    assign channel_clock_phase = control_ff[CTRL_CHANNEL_PH_BIT];
    assign serial_clock_phase = control_ff[CTRL_SERIAL_PH_BIT];

    // ---------------- pin synchronisers ----------------
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1_ff;
    logic [PIN_N-1:0] pin_s2_ff;
    logic [PIN_N-1:0] pin_s3_ff;
    logic [PIN_N-1:0] pin_lvl_ff;
    logic [PIN_N-1:0] pin_prev_ff;
    logic [PIN_N-1:0] pin_rise;
    logic [PIN_N-1:0] pin_fall;

    assign pin_raw = {CHANNEL_CLK_PIN_IN, EXT_MASTER_CLK_IN, VREF_EXT_PIN_IN};

    // no reset on the synchronisers so the strap level travels through them during reset
    generate
        for (genvar i = 0; i < PIN_N; i++) begin : g_pin
            always_ff @(posedge CLK_SYS_IN) begin
                pin_s1_ff[i] <= pin_raw[i];
                pin_s2_ff[i] <= pin_s1_ff[i];
                pin_s3_ff[i] <= pin_s2_ff[i];
                if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                    pin_lvl_ff[i] <= pin_s3_ff[i];
                end
                pin_prev_ff[i] <= pin_lvl_ff[i];
            end
            assign pin_rise[i] = pin_lvl_ff[i] & ~pin_prev_ff[i];
            assign pin_fall[i] = ~pin_lvl_ff[i] & pin_prev_ff[i];
        end
    endgenerate

    // ---------------- register port ----------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            clocks_per_field_ff <= CPF_RESET;
            nominal_increment_ff <= INC_RESET;
            serial_divider_ff <= SERIAL_DIV_RESET;
            channel_divider_ff <= CHANNEL_DIV_RESET;
            control_ff <= CTRL_RESET;
        end else if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                CPF_LOW_ADDR: clocks_per_field_ff[7:0] <= REG_WDATA_IN;
                CPF_MID_ADDR: clocks_per_field_ff[15:8] <= REG_WDATA_IN;
                CPF_HIGH_ADDR: clocks_per_field_ff[17:16] <= REG_WDATA_IN[1:0];
                INC_LOW_ADDR: nominal_increment_ff[7:0] <= REG_WDATA_IN;
                INC_MID_ADDR: nominal_increment_ff[15:8] <= REG_WDATA_IN;
                INC_HIGH_ADDR: nominal_increment_ff[21:16] <= REG_WDATA_IN[5:0];
                SERIAL_DIV_ADDR: serial_divider_ff <= REG_WDATA_IN[DIV_W-1:0];
                CHANNEL_DIV_ADDR: channel_divider_ff <= REG_WDATA_IN[DIV_W-1:0];
                CONTROL_ADDR: control_ff <= REG_WDATA_IN[CTRL_W-1:0];
                default: ;
            endcase
        end
    end

    logic xtal_sel_ff;
    logic match_ff;
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        case (REG_ADDR_IN)
            CPF_LOW_ADDR: nxt_rdata = clocks_per_field_ff[7:0];
            CPF_MID_ADDR: nxt_rdata = clocks_per_field_ff[15:8];
            CPF_HIGH_ADDR: nxt_rdata = {6'h00, clocks_per_field_ff[17:16]};
            INC_LOW_ADDR: nxt_rdata = nominal_increment_ff[7:0];
            INC_MID_ADDR: nxt_rdata = nominal_increment_ff[15:8];
            INC_HIGH_ADDR: nxt_rdata = {2'h0, nominal_increment_ff[21:16]};
            SERIAL_DIV_ADDR: nxt_rdata = {2'h0, serial_divider_ff};
            CHANNEL_DIV_ADDR: nxt_rdata = {2'h0, channel_divider_ff};
            CONTROL_ADDR: nxt_rdata = {4'h0, control_ff};
            STATUS_ADDR: nxt_rdata = {6'h00, match_ff, xtal_sel_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= nxt_rdata;
        end else begin
            REG_RDATA_OUT <= 8'h00;
        end
    end

    // ---------------- crystal strap ----------------
    // channel pin is released during reset so the board strap can be seen
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            xtal_sel_ff <= pin_lvl_ff[PIN_STRAP];
            CHANNEL_SELECT_CLK_OE_N_OUT <= 1'b1;
        end else begin
            CHANNEL_SELECT_CLK_OE_N_OUT <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            XTAL_SELECT_OUT <= 1'b0;
        end else begin
            XTAL_SELECT_OUT <= xtal_sel_ff;
        end
    end

    // ---------------- master clock synthesis ----------------
    logic [ACC_W-1:0] phase_acc_ff;
    logic [ACC_W-1:0] eff_inc;
    logic signed [TRIM_W-1:0] trim_ff;
    logic acc_prev_ff;
    logic master_rise;

    // clocked by the crystal reference that also feeds the pixel clock synthesis
    assign eff_inc = {1'b0, nominal_increment_ff}
                   + {{(ACC_W-TRIM_W){trim_ff[TRIM_W-1]}}, trim_ff};

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            phase_acc_ff <= '0;
            acc_prev_ff <= 1'b0;
        end else begin
            phase_acc_ff <= phase_acc_ff + eff_inc;
            acc_prev_ff <= phase_acc_ff[ACC_W-1];
        end
    end

    assign master_rise = phase_acc_ff[ACC_W-1] & ~acc_prev_ff;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            MASTER_AUDIO_CLK_OUT <= 1'b0;
        end else begin
            MASTER_AUDIO_CLK_OUT <= phase_acc_ff[ACC_W-1];
        end
    end

    // ---------------- field lock loop ----------------
    logic vref_int_prev_ff;
    logic field_evt;
    logic [CPF_W-1:0] field_cnt_ff;
    logic cnt_short;
    logic cnt_long;
    logic trim_max;
    logic trim_min;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            vref_int_prev_ff <= 1'b0;
        end else begin
            vref_int_prev_ff <= VREF_INT_IN;
        end
    end

    assign field_evt = vertical_ref_select ? pin_rise[PIN_VREF]
                                           : (VREF_INT_IN & ~vref_int_prev_ff);
    assign cnt_short = field_cnt_ff < clocks_per_field_ff;
    assign cnt_long = field_cnt_ff > clocks_per_field_ff;
    assign trim_max = trim_ff == {1'b0, {(TRIM_W-1){1'b1}}};
    assign trim_min = trim_ff == {1'b1, {(TRIM_W-1){1'b0}}};

    // master clocks are counted from one field start to the next
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            field_cnt_ff <= '0;
        end else if (field_evt) begin
            field_cnt_ff <= {{(CPF_W-1){1'b0}}, master_rise};
        end else if (master_rise && field_cnt_ff != {CPF_W{1'b1}}) begin
            field_cnt_ff <= field_cnt_ff + 1'b1;
        end
    end

    // one step per field keeps the loop very slow, so field jitter barely moves the clock
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            trim_ff <= TRIM_RESET;
        end else if (loop_open_select) begin
            trim_ff <= TRIM_RESET;
        end else if (field_evt && cnt_short && !trim_max) begin
            trim_ff <= trim_ff + TRIM_W'(1);
        end else if (field_evt && cnt_long && !trim_min) begin
            trim_ff <= trim_ff - TRIM_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            match_ff <= 1'b0;
        end else if (field_evt) begin
            match_ff <= !cnt_short && !cnt_long;
        end
    end

    // ---------------- serial bit clock ----------------
    logic mclk_edge;
    logic [DIV_W-1:0] serial_cnt_ff;
    logic serial_int_ff;

    // the external master input is expected to be the master clock output looped back
    assign mclk_edge = serial_clock_phase ? pin_rise[PIN_MCLK] : pin_fall[PIN_MCLK];

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            serial_cnt_ff <= '0;
            serial_int_ff <= 1'b0;
        end else if (mclk_edge) begin
            if (serial_cnt_ff >= serial_divider_ff) begin
                serial_cnt_ff <= '0;
                serial_int_ff <= ~serial_int_ff;
            end else begin
                serial_cnt_ff <= serial_cnt_ff + 1'b1;
            end
        end
    end

    // ---------------- channel select clock ----------------
    logic serial_prev_ff;
    logic serial_rise;
    logic [DIV_W-1:0] channel_cnt_ff;
    logic channel_int_ff;

    assign serial_rise = serial_int_ff & ~serial_prev_ff;

    // a channel divider of zero stops the channel clock
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            serial_prev_ff <= 1'b0;
            channel_cnt_ff <= '0;
            channel_int_ff <= 1'b0;
        end else begin
            serial_prev_ff <= serial_int_ff;
            if (serial_rise && channel_divider_ff != '0) begin
                if (channel_cnt_ff >= channel_divider_ff - 1'b1) begin
                    channel_cnt_ff <= '0;
                    channel_int_ff <= ~channel_int_ff;
                end else begin
                    channel_cnt_ff <= channel_cnt_ff + 1'b1;
                end
            end
        end
    end

    // channel toggles on the internal rising edge; inverting the serial output
    // moves that edge onto the falling edge seen at the pin
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            SERIAL_BIT_CLK_OUT <= 1'b0;
            CHANNEL_SELECT_CLK_OUT <= 1'b0;
        end else begin
            SERIAL_BIT_CLK_OUT <= channel_clock_phase ? serial_int_ff : ~serial_int_ff;
            CHANNEL_SELECT_CLK_OUT <= channel_int_ff;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);

    cpf_high_read_a: assert property (REG_RD_IN && REG_ADDR_IN == CPF_HIGH_ADDR
        |=> REG_RDATA_OUT == {6'h00, $past(clocks_per_field_ff[17:16])})
        else $error("clocks per field high byte read wrong");

    inc_high_read_a: assert property (REG_RD_IN && REG_ADDR_IN == INC_HIGH_ADDR
        |=> REG_RDATA_OUT == {2'h0, $past(nominal_increment_ff[21:16])})
        else $error("nominal increment high byte read wrong");

    loop_open_a: assert property (loop_open_select
        |=> trim_ff == TRIM_RESET)
        else $error("trim not cleared with loop open");

    sequence field_short_s;
        field_evt && cnt_short && !loop_open_select && !trim_max;
    endsequence
    sequence field_long_s;
        field_evt && cnt_long && !loop_open_select && !trim_min;
    endsequence

    trim_up_a: assert property (field_short_s ##1 !loop_open_select
        |-> trim_ff == $past(trim_ff) + TRIM_W'(1))
        else $error("trim did not rise on short field");

    trim_down_a: assert property (field_long_s ##1 !loop_open_select
        |-> trim_ff == $past(trim_ff) - TRIM_W'(1))
        else $error("trim did not fall on long field");

    vref_ext_a: assert property (vertical_ref_select && !pin_rise[PIN_VREF]
        |-> !field_evt)
        else $error("field event without external reference edge");

    serial_step_a: assert property ($changed(serial_int_ff)
        |-> $past(mclk_edge) && $past(serial_cnt_ff) >= $past(serial_divider_ff))
        else $error("serial clock toggled off its count");

    serial_edge_a: assert property (!serial_clock_phase && pin_rise[PIN_MCLK]
        |=> $stable(serial_cnt_ff) && $stable(serial_int_ff))
        else $error("serial divider moved on wrong master edge");

    channel_step_a: assert property ($changed(channel_int_ff)
        |-> $past(serial_rise) && $past(channel_divider_ff) != '0)
        else $error("channel clock toggled off a serial edge");

    channel_phase_a: assert property ($changed(channel_int_ff) && $stable(channel_clock_phase)
        |=> SERIAL_BIT_CLK_OUT == channel_clock_phase)
        else $error("channel edge on wrong serial edge");

    strap_hold_a: assert property (##1 RESETN_IN
        |-> $stable(xtal_sel_ff) && XTAL_SELECT_OUT == $past(xtal_sel_ff))
        else $error("crystal select changed after reset");

endmodule : field_locked_audio_clock_gen

`default_nettype wire

// ===== verification/audio_sink_model.sv
`timescale 1ns/100ps
`default_nettype none

module audio_sink_model #(
    parameter int HALF = 8,
    parameter logic STRAP = 1'b1
) (
    input wire logic clk_in,
    input wire logic loop_in,
    input wire logic master_in,
    input wire logic chan_in,
    input wire logic chan_oe_n_in,
    output logic ext_clk_out,
    output logic chan_pin_out
);
    logic own_clk = 1'b0;
    int cnt = 0;

    // converter clock kept slower than a sixth of the system clock for the pin synchroniser
    always @(posedge clk_in) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            own_clk <= ~own_clk;
        end
    end

    assign ext_clk_out = loop_in ? master_in : own_clk;
    // pin is pulled to the strap level while the device releases it
    assign chan_pin_out = chan_oe_n_in ? STRAP : chan_in;
endmodule // audio_sink_model

`default_nettype wire

// ===== verification/test_field_locked_audio_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none

module test_field_locked_audio_clock_gen;
    import audio_clock_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic vref_int = 1'b0;
    logic vref_ext = 1'b0;
    logic loop_sel = 1'b0;
    logic [7:0] rdata;
    logic ext_clk, chan_pin, mclk, sclk, lrclk, oe_n, xsel;
    logic ext_q, sclk_q, lr_q, last_rise, s_ph, lr_ph;
    logic [7:0] model [0:255];
    logic [7:0] tab [12] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h38,
                             8'h39, 8'h3a, 8'h3b, 8'h3f};
    int fails = 0;
    int total_checks = 0;
    int fcnt = 0;
    bit [31:0] lfsr_st = 32'hc187_0ceb;

    always #20 clk = ~clk;

    field_locked_audio_clock_gen i_dut (
        .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .VREF_INT_IN(vref_int),
        .VREF_EXT_PIN_IN(vref_ext), .EXT_MASTER_CLK_IN(ext_clk), .CHANNEL_CLK_PIN_IN(chan_pin),
        .MASTER_AUDIO_CLK_OUT(mclk), .SERIAL_BIT_CLK_OUT(sclk), .CHANNEL_SELECT_CLK_OUT(lrclk),
        .CHANNEL_SELECT_CLK_OE_N_OUT(oe_n), .XTAL_SELECT_OUT(xsel));

    audio_sink_model #(.HALF(8), .STRAP(1'b1)) i_sink (
        .clk_in(clk), .loop_in(loop_sel), .master_in(mclk), .chan_in(lrclk),
        .chan_oe_n_in(oe_n), .ext_clk_out(ext_clk), .chan_pin_out(chan_pin));

    // internal fields of 1000 cycles, external fields of 2000 so a wrong select shows
    always @(posedge clk) begin
        fcnt <= fcnt + 1;
        vref_int <= (fcnt % 1000) < 10;
        vref_ext <= (fcnt % 2000) < 10;
    end

    // remembers which master edge preceded a serial toggle, and serial level at a channel toggle
    always @(posedge clk) begin
        ext_q <= ext_clk;
        sclk_q <= sclk;
        lr_q <= lrclk;
        if (ext_clk !== ext_q) last_rise <= ext_clk;
        if (sclk !== sclk_q) s_ph <= last_rise;
        if (lrclk !== lr_q) lr_ph <= sclk;
    end

    function automatic bit [31:0] rnd();
        lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
        return lfsr_st;
    endfunction

    function automatic logic [7:0] mask(input logic [7:0] a);
        case (a)
            CPF_LOW_ADDR, CPF_MID_ADDR, INC_LOW_ADDR, INC_MID_ADDR: return 8'hff;
            CPF_HIGH_ADDR: return 8'h03;
            INC_HIGH_ADDR, SERIAL_DIV_ADDR, CHANNEL_DIV_ADDR: return 8'h3f;
            CONTROL_ADDR: return 8'h0f;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        model[a] = d & mask(a);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic cmp_reg(input logic [7:0] a);
        logic [7:0] d;
        rd_reg(a, d);
        if (a == STATUS_ADDR) check("status strap", d & 8'h01, 8'h01);
        else check($sformatf("reg %0h", a), d, model[a]);
    endtask

    task automatic wait_tog(input int sel, output int cyc);
        logic v0;
        v0 = sel ? lrclk : sclk;
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while ((sel ? lrclk : sclk) === v0 && cyc < 5000);
        if (cyc >= 5000) begin
            check("toggle wait", 0, 1);
            summarize();
        end
    endtask

    task automatic set_inc(input longint v);
        wr_reg(INC_LOW_ADDR, v[7:0]);
        wr_reg(INC_MID_ADDR, v[15:8]);
        wr_reg(INC_HIGH_ADDR, v[23:16]);
    endtask

    task automatic status_is(input logic [7:0] e, input string what);
        logic [7:0] d;
        rd_reg(STATUS_ADDR, d);
        check(what, d, e);
    endtask

    initial begin
        int d, l, ph, n, c;
        longint e, inc;
        logic p;
        model = '{default: 8'h00};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("strap select", xsel, 1'b1);
        check("channel drive", oe_n, 1'b0);
        foreach (tab[i]) cmp_reg(tab[i]);
        @(posedge clk);
        #1;
        check("read data after", rdata, 8'h00);
        foreach (tab[i]) wr_reg(tab[i], 8'(rnd()));
        foreach (tab[i]) cmp_reg(tab[i]);
        $display("test registers done");

        for (int i = 0; i < 4; i++) begin
            d = rnd() % 4;
            l = 1 + rnd() % 4;
            ph = (i < 2) ? 3 * i : rnd() % 4;
            wr_reg(SERIAL_DIV_ADDR, 8'(d));
            wr_reg(CHANNEL_DIV_ADDR, 8'(l));
            wr_reg(CONTROL_ADDR, 8'(ph));
            repeat (3) wait_tog(0, c);
            check("serial half period", c, 16 * (d + 1));
            check("serial edge phase", s_ph, ph % 2);
            repeat (3) wait_tog(1, c);
            check("channel half period", c, 32 * (d + 1) * l);
            check("channel edge phase", lr_ph, ph / 2);
        end
        $display("test dividers done");

        inc = 64'h0008_0000 + rnd() % 32'h0008_0000;
        wr_reg(CONTROL_ADDR, 8'h08);
        set_inc(inc);
        repeat (50) @(posedge clk);
        #1;
        n = 0;
        p = mclk;
        repeat (4000) begin
            @(posedge clk);
            #1;
            if (mclk === 1'b1 && p === 1'b0) n++;
            p = mclk;
        end
        e = (64'd4000 * inc) >> 23;
        check("master rate", (n - e <= 1) && (e - n <= 1), 1'b1);
        $display("test master rate done");

        set_inc(64'h0010_0000);
        wr_reg(CPF_HIGH_ADDR, 8'h00);
        wr_reg(CPF_MID_ADDR, 8'h00);
        wr_reg(CPF_LOW_ADDR, 8'h7d);
        wr_reg(CONTROL_ADDR, 8'h00);
        repeat (3500) @(posedge clk);
        status_is(8'h03, "field count match");
        wr_reg(CPF_LOW_ADDR, 8'hc8);
        repeat (2500) @(posedge clk);
        status_is(8'h01, "field count miss");
        // fields now carry more master clocks than the target, so the trim steps down
        wr_reg(CPF_LOW_ADDR, 8'h64);
        repeat (2500) @(posedge clk);
        status_is(8'h01, "field count over");
        wr_reg(CPF_LOW_ADDR, 8'hfa);
        wr_reg(CONTROL_ADDR, 8'h04);
        repeat (6500) @(posedge clk);
        status_is(8'h03, "external field match");
        $display("test field loop done");

        wr_reg(CONTROL_ADDR, 8'h0b);
        wr_reg(SERIAL_DIV_ADDR, 8'h00);
        loop_sel <= 1'b1;
        repeat (3) wait_tog(0, c);
        check("looped serial half period", c, 8);
        $display("test loopback done");
        summarize();
    end
endmodule // test_field_locked_audio_clock_gen

`default_nettype wire
